// ==== pkg/gsr_pkg.sv ====
package gsr_pkg;

	localparam int          GSR_MODULES   = 2;
	localparam int          GSR_IDX_W     = 1;
	localparam logic [4:0]  GSR_PRI_ADDR  = 5'h01;
	localparam logic [4:0]  GSR_SEC_BASE  = 5'h00;

	localparam int          GSR_STB_RQS   = 6;
	localparam int          GSR_STB_ESB   = 5;
	localparam int          GSR_STB_MAV   = 4;
	localparam logic [7:0]  GSR_SUM_MASK  = 8'h30;

	localparam int          GSR_EV_CMD    = 5;
	localparam int          GSR_EV_EXE    = 4;
	localparam int          GSR_EV_DEV    = 3;
	localparam int          GSR_EV_QRY    = 2;
	localparam int          GSR_EV_OPC    = 0;
	localparam logic [7:0]  GSR_EV_UNUSED = 8'hC2;

	localparam logic [7:0]  GSR_ESR_RST   = 8'h00;
	localparam logic [7:0]  GSR_ESE_RST   = 8'h00;
	localparam logic [7:0]  GSR_SRE_RST   = 8'h00;

	typedef enum logic [3:0] {
		GSR_OP_NONE   = 4'h0,
		GSR_OP_CLS    = 4'h1,
		GSR_OP_ESE_WR = 4'h2,
		GSR_OP_ESE_RD = 4'h3,
		GSR_OP_ESR_RD = 4'h4,
		GSR_OP_SRE_WR = 4'h5,
		GSR_OP_SRE_RD = 4'h6,
		GSR_OP_STB_RD = 4'h7,
		GSR_OP_SPOLL  = 4'h8,
		GSR_OP_OPC    = 4'h9
	} gsr_op_t;

	typedef enum logic [0:0] {
		GSR_OPC_IDLE  = 1'b0,
		GSR_OPC_ARMED = 1'b1
	} gsr_opc_t;

	typedef struct packed {
		logic       valid;
		gsr_op_t    op;
		logic [4:0] pri_addr;
		logic [4:0] sec_addr;
		logic [7:0] data;
	} gsr_cmd_t;

	typedef struct packed {
		logic syntax_err;
		logic range_err;
		logic conflict_err;
		logic device_err;
		logic no_response;
		logic op_done;
		logic query_ready;
	} gsr_evt_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} gsr_ans_t;

endpackage : gsr_pkg

// ==== logic/gsr_status.sv ====
`timescale 1ns/1ps
module gsr_status (
	input  wire logic                                 core_clk,
	input  wire logic                                 reset,
	input  wire gsr_pkg::gsr_cmd_t                    cmd,
	input  wire gsr_pkg::gsr_evt_t [gsr_pkg::GSR_MODULES-1:0] evt,
	input  wire logic [gsr_pkg::GSR_MODULES-1:0]      mav_pending,
	output gsr_pkg::gsr_ans_t                         ans,
	output logic [gsr_pkg::GSR_MODULES-1:0][7:0]      status_byte,
	output logic                                      service_request
);
	import gsr_pkg::*;

	typedef struct packed {
		logic [GSR_MODULES-1:0][7:0] standard_event_flags;
		logic [GSR_MODULES-1:0][7:0] ese;
		logic [GSR_MODULES-1:0][7:0] sre;
		logic [GSR_MODULES-1:0]      rqs;
		logic [GSR_MODULES-1:0]      mss_q;
		gsr_opc_t [GSR_MODULES-1:0]  opc;
		gsr_ans_t                    ans;
	} gsr_state_t;

	gsr_state_t st;
	gsr_state_t next_st;

	function automatic logic gsr_hit(input gsr_cmd_t c, input int idx);
		gsr_hit = c.valid && (c.pri_addr == GSR_PRI_ADDR)
			&& (c.sec_addr == (GSR_SEC_BASE + 5'(idx)));
	endfunction : gsr_hit

	function automatic logic [7:0] gsr_sets(input gsr_evt_t e, input logic opc_fire);
		gsr_sets = 8'h00;
		gsr_sets[GSR_EV_CMD] = e.syntax_err;
		gsr_sets[GSR_EV_EXE] = e.range_err;
		gsr_sets[GSR_EV_DEV] = e.device_err | e.conflict_err;
		gsr_sets[GSR_EV_QRY] = e.no_response;
		gsr_sets[GSR_EV_OPC] = opc_fire | e.query_ready;
	endfunction : gsr_sets

	logic [GSR_MODULES-1:0] esb;
	logic [GSR_MODULES-1:0] mss;

	// status byte per module
	always_comb begin
		for (int i = 0; i < GSR_MODULES; i++) begin
			esb[i] = |(st.standard_event_flags[i] & st.ese[i]);
			status_byte[i] = 8'h00;
			status_byte[i][GSR_STB_ESB] = esb[i];
			status_byte[i][GSR_STB_MAV] = mav_pending[i];
			mss[i] = |(status_byte[i] & st.sre[i] & GSR_SUM_MASK);
			status_byte[i][GSR_STB_RQS] = mss[i];
		end
	end

	always_comb begin
		logic       cls;
		logic       opc_fire;
		logic [7:0] sets;
		cls      = 1'b0;
		opc_fire = 1'b0;
		sets     = 8'h00;
		next_st  = st;
		next_st.ans.valid = 1'b0;
		for (int i = 0; i < GSR_MODULES; i++) begin
			cls = gsr_hit(cmd, i) && (cmd.op == GSR_OP_CLS);
			opc_fire = (st.opc[i] == GSR_OPC_ARMED) && evt[i].op_done;
			sets = gsr_sets(evt[i], opc_fire) & ~GSR_EV_UNUSED;
			// completion tracking
			case (st.opc[i])
				GSR_OPC_IDLE: begin
					if (gsr_hit(cmd, i) && (cmd.op == GSR_OP_OPC)) begin
						next_st.opc[i] = GSR_OPC_ARMED;
					end
				end
				GSR_OPC_ARMED: begin
					if (evt[i].op_done) begin
						next_st.opc[i] = GSR_OPC_IDLE;
					end
				end
				default: begin
					next_st.opc[i] = GSR_OPC_IDLE;
				end
			endcase
			if (cls) begin
				next_st.opc[i] = GSR_OPC_IDLE;
			end
			// flags hold until read or cleared; a new event wins over the clear
			if (cls || (gsr_hit(cmd, i) && (cmd.op == GSR_OP_ESR_RD))) begin
				next_st.standard_event_flags[i] = sets;
			end else begin
				next_st.standard_event_flags[i] = st.standard_event_flags[i] | sets;
			end
			// pending service request latched on a rising summary
			next_st.mss_q[i] = mss[i];
			if (cls || (gsr_hit(cmd, i) && (cmd.op == GSR_OP_SPOLL))) begin
				next_st.rqs[i] = mss[i] & ~st.mss_q[i];
			end else begin
				next_st.rqs[i] = st.rqs[i] | (mss[i] & ~st.mss_q[i]);
			end
			if (gsr_hit(cmd, i)) begin
				case (cmd.op)
					GSR_OP_ESE_WR: next_st.ese[i] = cmd.data;
					GSR_OP_SRE_WR: begin
						next_st.sre[i] = cmd.data;
						next_st.sre[i][GSR_STB_RQS] = 1'b0;
					end
					GSR_OP_ESE_RD: begin
						next_st.ans.valid = 1'b1;
						next_st.ans.data  = st.ese[i];
					end
					GSR_OP_SRE_RD: begin
						next_st.ans.valid = 1'b1;
						next_st.ans.data  = st.sre[i];
					end
					GSR_OP_ESR_RD: begin
						next_st.ans.valid = 1'b1;
						next_st.ans.data  = st.standard_event_flags[i];
					end
					GSR_OP_STB_RD: begin
						next_st.ans.valid = 1'b1;
						next_st.ans.data  = status_byte[i];
					end
					GSR_OP_SPOLL: begin
						next_st.ans.valid = 1'b1;
						next_st.ans.data  = status_byte[i];
						next_st.ans.data[GSR_STB_RQS] = st.rqs[i];
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
			for (int i = 0; i < GSR_MODULES; i++) begin
				st.standard_event_flags[i] <= GSR_ESR_RST;
				st.ese[i] <= GSR_ESE_RST;
				st.sre[i] <= GSR_SRE_RST;
				st.opc[i] <= GSR_OPC_IDLE;
			end
		end else begin
			st <= next_st;
		end
	end

	assign ans             = st.ans;
	assign service_request = |st.rqs;

	// checks on module 0
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	logic hit0;
	assign hit0 = gsr_hit(cmd, 0);

	a_unused_bits: assert property ((st.standard_event_flags[0] & GSR_EV_UNUSED) == 8'h00)
		else $error("unused event bit set");
	a_mav_follow: assert property (status_byte[0][GSR_STB_MAV] == mav_pending[0])
		else $error("message available does not follow queue");
	a_esb_sum: assert property (status_byte[0][GSR_STB_ESB] == |(st.standard_event_flags[0] & st.ese[0]))
		else $error("event summary wrong");
	a_mss_sum: assert property (status_byte[0][GSR_STB_RQS] ==
		|({st.standard_event_flags[0] != 8'h00 && esb[0], mav_pending[0]} & {st.sre[0][5], st.sre[0][4]}))
		else $error("master summary wrong");
	a_syntax_sets: assert property (evt[0].syntax_err |=> st.standard_event_flags[0][GSR_EV_CMD])
		else $error("syntax error not flagged");
	a_conflict_exe: assert property (evt[0].conflict_err && !evt[0].range_err
		&& !(hit0 && cmd.op inside {GSR_OP_ESR_RD, GSR_OP_CLS}) && !st.standard_event_flags[0][GSR_EV_EXE]
		|=> st.standard_event_flags[0][GSR_EV_DEV] && !st.standard_event_flags[0][GSR_EV_EXE])
		else $error("conflict flagged as range error");
	a_query_sets: assert property (evt[0].no_response |=> st.standard_event_flags[0][GSR_EV_QRY])
		else $error("query error not flagged");
	a_esr_read: assert property (hit0 && cmd.op == GSR_OP_ESR_RD && evt[0] == '0
		|=> ans.valid && ans.data == $past(st.standard_event_flags[0]) && st.standard_event_flags[0] == 8'h00)
		else $error("event read did not return and clear");
	a_sticky_hold: assert property (st.standard_event_flags[0][GSR_EV_CMD] && !(hit0 &&
		cmd.op inside {GSR_OP_ESR_RD, GSR_OP_CLS}) |=> st.standard_event_flags[0][GSR_EV_CMD])
		else $error("event flag dropped");
	a_cls_idle: assert property (hit0 && cmd.op == GSR_OP_CLS ##1 !evt[0].op_done
		|-> st.opc[0] == GSR_OPC_IDLE)
		else $error("clear status left completion armed");
	a_ese_wr: assert property (hit0 && cmd.op == GSR_OP_ESE_WR
		|=> st.ese[0] == $past(cmd.data))
		else $error("event enable not written");
	a_spoll_rqs: assert property (hit0 && cmd.op == GSR_OP_SPOLL
		|=> ans.valid && ans.data[GSR_STB_RQS] == $past(st.rqs[0]))
		else $error("poll request bit wrong");
	a_opc_done: assert property (st.opc[0] == GSR_OPC_ARMED && evt[0].op_done
		|=> st.standard_event_flags[0][GSR_EV_OPC])
		else $error("completion not flagged");
	a_range_sets: assert property (evt[0].range_err |=> st.standard_event_flags[0][GSR_EV_EXE])
		else $error("range error not flagged");
	a_device_sets: assert property (evt[0].device_err |=> st.standard_event_flags[0][GSR_EV_DEV])
		else $error("device error not flagged");
	a_qready_sets: assert property (evt[0].query_ready |=> st.standard_event_flags[0][GSR_EV_OPC])
		else $error("query results not flagged");
	a_opc_unarmed: assert property (st.opc[0] == GSR_OPC_IDLE && evt[0].op_done
		&& !evt[0].query_ready && !st.standard_event_flags[0][GSR_EV_OPC]
		|=> !st.standard_event_flags[0][GSR_EV_OPC])
		else $error("completion flagged while not armed");
	a_sre_bit6: assert property (!st.sre[0][GSR_STB_RQS])
		else $error("service enable holds the summary position");
	a_sum_masked: assert property ((st.sre[0] & GSR_SUM_MASK) == 8'h00
		|-> !status_byte[0][GSR_STB_RQS])
		else $error("summary fed by an unused position");
	a_rqs_latch: assert property (mss[0] && !st.mss_q[0] |=> st.rqs[0])
		else $error("rising summary not latched as request");
	a_cls_clear: assert property (hit0 && cmd.op == GSR_OP_CLS && evt[0] == '0
		&& !(mss[0] && !st.mss_q[0]) |=> st.standard_event_flags[0] == 8'h00 && !st.rqs[0])
		else $error("clear status left flags or request");
	a_stb_read: assert property (hit0 && cmd.op == GSR_OP_STB_RD
		|=> ans.valid && ans.data == $past(status_byte[0]))
		else $error("status byte read wrong");
	a_ese_read: assert property (hit0 && cmd.op == GSR_OP_ESE_RD
		|=> ans.valid && ans.data == $past(st.ese[0]))
		else $error("event enable read wrong");
	a_read_answer: assert property (hit0 && cmd.op inside {GSR_OP_ESE_RD, GSR_OP_SRE_RD,
		GSR_OP_ESR_RD, GSR_OP_STB_RD, GSR_OP_SPOLL} |=> ans.valid)
		else $error("addressed read gave no answer");
	a_mod1_apart: assert property (gsr_hit(cmd, 1) && cmd.op == GSR_OP_ESE_WR
		|=> st.ese[0] == $past(st.ese[0]))
		else $error("write to other module changed module 0");

	c_poll: cover property (st.rqs[0] ##1 hit0 && cmd.op == GSR_OP_SPOLL);
	c_esr_read: cover property (st.standard_event_flags[0] != 8'h00 ##1 hit0 && cmd.op == GSR_OP_ESR_RD);
	c_opc_cycle: cover property (hit0 && cmd.op == GSR_OP_OPC ##[1:20] evt[0].op_done);
	c_mss_rise: cover property (!mss[0] ##1 mss[0]);
	c_mod1_read: cover property (gsr_hit(cmd, 1) && cmd.op == GSR_OP_ESR_RD);

endmodule : gsr_status

// ==== dv/gsr_ctrl_model.sv ====
`timescale 1ns/1ps
module gsr_ctrl_model (
	input  wire logic              core_clk,
	input  wire gsr_pkg::gsr_ans_t ans,
	output gsr_pkg::gsr_cmd_t      cmd
);
	import gsr_pkg::*;
	initial cmd = '0;
	// one command, addressed at primary plus secondary address
	task automatic xfer(input gsr_op_t op, input logic [4:0] pa, input logic [4:0] sa,
		input logic [7:0] d, output logic got, output logic [7:0] rd);
		@(posedge core_clk);
		cmd <= '{1'b1, op, pa, sa, d};
		@(posedge core_clk);
		cmd <= '{1'b0, GSR_OP_NONE, ~pa, ~sa, ~d};
		#1;
		got = ans.valid;
		rd = ans.data;
	endtask : xfer
endmodule : gsr_ctrl_model

// ==== dv/gsr_status_test.sv ====
`timescale 1ns/1ps
module gsr_status_test;
	import gsr_pkg::*;
	logic                        core_clk;
	logic                        reset;
	gsr_evt_t [GSR_MODULES-1:0]  evt;
	logic [GSR_MODULES-1:0]      mav_pending;
	gsr_cmd_t                    cmd;
	gsr_ans_t                    ans;
	logic [GSR_MODULES-1:0][7:0] status_byte;
	logic                        service_request;
	logic                        got;
	logic [7:0]                  rd;
	int                          mismatches;
	int                          checks;
	int                          cycles;
	localparam logic [7:0] EV_EXP [7] = '{8'h20, 8'h10, 8'h08, 8'h08, 8'h04, 8'h00, 8'h01};
	gsr_status u_gsr_status (.core_clk(core_clk), .reset(reset), .cmd(cmd), .evt(evt),
		.mav_pending(mav_pending), .ans(ans), .status_byte(status_byte),
		.service_request(service_request));
	gsr_ctrl_model u_gsr_ctrl_model (.core_clk(core_clk), .ans(ans), .cmd(cmd));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic q(input gsr_op_t op, input logic [7:0] d);
		u_gsr_ctrl_model.xfer(op, GSR_PRI_ADDR, GSR_SEC_BASE, d, got, rd);
	endtask : q
	task automatic q1(input gsr_op_t op, input logic [7:0] d);
		u_gsr_ctrl_model.xfer(op, GSR_PRI_ADDR, GSR_SEC_BASE + 5'h1, d, got, rd);
	endtask : q1
	task automatic pulse(input logic [6:0] v);
		@(posedge core_clk);
		evt[0] <= gsr_evt_t'(v);
		@(posedge core_clk);
		evt <= '0;
		repeat (3) @(posedge core_clk);
	endtask : pulse
	task automatic t_events();
		for (int i = 0; i < 7; i++) begin
			pulse(7'h40 >> i);
			q(GSR_OP_ESR_RD, 8'h00);
			check({7'h0, got}, 8'h01);
			check(rd, EV_EXP[i]);
			q(GSR_OP_ESR_RD, 8'h00);
			check(rd, 8'h00);
		end
		q(GSR_OP_OPC, 8'h00);
		pulse(7'h02);
		q(GSR_OP_ESR_RD, 8'h00);
		check(rd, 8'h01);
	endtask : t_events
	task automatic t_summary();
		q(GSR_OP_ESE_WR, 8'hFF);
		q(GSR_OP_ESE_RD, 8'h00);
		check(rd, 8'hFF);
		q(GSR_OP_SRE_WR, 8'h20);
		pulse(7'h40);
		#1;
		check(status_byte[0], 8'h60);
		check(status_byte[1], 8'h00);
		check({7'h0, service_request}, 8'h01);
		q(GSR_OP_SPOLL, 8'h00);
		check(rd, 8'h60);
		@(posedge core_clk);
		#1;
		check({7'h0, service_request}, 8'h00);
		q(GSR_OP_STB_RD, 8'h00);
		check(rd, 8'h60);
		q(GSR_OP_SRE_WR, 8'h8F);
		#1;
		check(status_byte[0], 8'h20);
		@(posedge core_clk);
		mav_pending <= 2'b01;
		#1;
		check(status_byte[0], 8'h30);
		@(posedge core_clk);
		mav_pending <= 2'b00;
		#1;
		check(status_byte[0], 8'h20);
		u_gsr_ctrl_model.xfer(GSR_OP_ESR_RD, GSR_PRI_ADDR + 5'h1, GSR_SEC_BASE, 8'h00, got, rd);
		check({7'h0, got}, 8'h00);
		q(GSR_OP_SRE_WR, 8'hFF);
		q(GSR_OP_SRE_RD, 8'h00);
		check(rd, 8'hBF);
		check({7'h0, service_request}, 8'h01);
		q(GSR_OP_CLS, 8'h00);
		check({7'h0, service_request}, 8'h00);
		check(status_byte[0], 8'h00);
		q(GSR_OP_ESR_RD, 8'h00);
		check(rd, 8'h00);
		q(GSR_OP_OPC, 8'h00);
		q(GSR_OP_CLS, 8'h00);
		pulse(7'h02);
		q(GSR_OP_ESR_RD, 8'h00);
		check(rd, 8'h00);
	endtask : t_summary
	task automatic t_module1();
		q1(GSR_OP_ESE_WR, 8'h10);
		q1(GSR_OP_ESE_RD, 8'h00);
		check(rd, 8'h10);
		q(GSR_OP_ESE_RD, 8'h00);
		check(rd, 8'hFF);
		@(posedge core_clk);
		evt[1] <= gsr_evt_t'(7'h20);
		@(posedge core_clk);
		evt <= '0;
		#1;
		check(status_byte[1], 8'h20);
		check(status_byte[0], 8'h00);
		q1(GSR_OP_ESR_RD, 8'h00);
		check(rd, 8'h10);
		q(GSR_OP_ESR_RD, 8'h00);
		check(rd, 8'h00);
		q1(GSR_OP_SRE_WR, 8'h10);
		@(posedge core_clk);
		mav_pending <= 2'b10;
		q1(GSR_OP_SPOLL, 8'h00);
		check(rd, 8'h50);
		@(posedge core_clk);
		mav_pending <= 2'b00;
	endtask : t_module1
	task automatic t_reset();
		pulse(7'h40);
		#1;
		check({7'h0, service_request}, 8'h01);
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		check(status_byte[0], 8'h00);
		check({7'h0, service_request}, 8'h00);
		q(GSR_OP_ESE_RD, 8'h00);
		check(rd, 8'h00);
		q(GSR_OP_ESR_RD, 8'h00);
		check(rd, 8'h00);
	endtask : t_reset
	always @(posedge core_clk) begin
		cycles++;
		if (cycles >= 2000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		reset = 1'b1;
		evt = '0;
		mav_pending = '0;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		check(status_byte[0], 8'h00);
		t_events();
		t_summary();
		t_module1();
		t_reset();
		end_of_test();
	end
endmodule : gsr_status_test
